/* src/bsm_consts.vh */
`ifndef BSM_CONSTS_VH
`define BSM_CONSTS_VH

// Register byte offsets (one 32-bit word each)
`define BSM_OFF_CTRL      12'h000
`define BSM_OFF_STATUS    12'h004
`define BSM_OFF_STATE     12'h008

// Control and enable register fields
`define BSM_CTRL_SCE_BIT  0
`define BSM_CTRL_RRE_BIT  1
`define BSM_CTRL_REQ_LSB  4
`define BSM_CTRL_REQ_MSB  6

// Status register fields
`define BSM_STS_SBP_BIT   0
`define BSM_STS_IBP_BIT   1
`define BSM_STS_RRF_BIT   2
`define BSM_STS_SCF_BIT   3

// Reset values
`define BSM_CTRL_RESET    32'h00000000

// State request codes
`define BSM_REQ_INSERTED  3'h1
`define BSM_REQ_ENABLED   3'h2
`define BSM_REQ_REMOVAL_REQUEST_ACTIVE    3'h3
`define BSM_REQ_ALLOWED   3'h4

// State encodings
`define BSM_ST_EMPTY      3'h0
`define BSM_ST_INSERTED   3'h1
`define BSM_ST_ENABLED    3'h2
`define BSM_ST_REMOVAL_REQUEST_ACTIVE     3'h3
`define BSM_ST_ALLOWED    3'h4

`endif

/* src/bsm_sync.v */
module bsm_sync #(
  parameter WIDTH = 3
) (
  // Clock and reset
  input  wire             clk,
  input  wire             arst_n,
  // Data
  input  wire [WIDTH-1:0] d_in,
  output wire [WIDTH-1:0] d_out
);

  reg [WIDTH-1:0] meta_q;
  reg [WIDTH-1:0] sync_q;

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_q <= {WIDTH{1'b0}};
      sync_q <= {WIDTH{1'b0}};
    end else begin
      meta_q <= d_in;
      sync_q <= meta_q;
    end
  end

  assign d_out = sync_q;

endmodule // bsm_sync

/* src/bsm_bay_state_machine.v */
// Notes on behaviour
// - Enabled goes Empty when presence drops
// - Removal Requested goes Empty on presence loss
// - Removal Allowed goes Empty on presence loss
// - Software requests ignored while bay empty
// - Only hardware presence loss enters Empty
// - Only the write act triggers software request transitions
// - Request field sits in control bits 6:4
// - With device present, any target reachable
// - Requests honoured in Empty when device present
// - Empty plus 001b gives Inserted
// - Empty plus 010b gives Enabled
// - Inserted plus 010b gives Enabled
// - Enabled plus 011b gives Removal Requested
// - Inserted plus 100b gives Removal Allowed
// - Removal Requested plus 010b gives Enabled
// - Removal Requested plus 100b gives Allowed
// - Occupied when either presence flag set
// - Arrival moves Empty to Inserted if enabled
// - Button with enable gives Removal Requested from Inserted or Enabled
`include "bsm_consts.vh"

module bsm_bay_state_machine #(
  parameter ADDR_W = 12
) (
  // Clock and reset
  input  wire              CLK_SYS,
  input  wire              ARST_N,
  // APB slave
  input  wire              PSEL,
  input  wire              PENABLE,
  input  wire              PWRITE,
  input  wire [ADDR_W-1:0] PADDR,
  input  wire [31:0]       PWDATA,
  input  wire [3:0]        PSTRB,
  output reg  [31:0]       PRDATA,
  output reg               PREADY,
  output reg               PSLVERR,
  // Bay pins
  input  wire              SERIAL_BUS_PRESENCE,
  input  wire              ISOCHRONOUS_BUS_PRESENCE,
  input  wire              REMOVAL_BUTTON,
  // State out
  output reg  [2:0]        BAY_STATE
);

  localparam [2:0] ST_EMPTY    = `BSM_ST_EMPTY;
  localparam [2:0] ST_INSERTED = `BSM_ST_INSERTED;
  localparam [2:0] ST_ENABLED  = `BSM_ST_ENABLED;
  localparam [2:0] ST_REMOVAL_REQUEST_ACTIVE   = `BSM_ST_REMOVAL_REQUEST_ACTIVE;
  localparam [2:0] ST_ALLOWED  = `BSM_ST_ALLOWED;

  // Maps a request code to its target state; unassigned codes give EMPTY,
  // which callers treat as "no move" since Empty is never a software target
  function [2:0] req_target;
    input [2:0] code;
    begin
      case (code)
        `BSM_REQ_INSERTED: req_target = ST_INSERTED;
        `BSM_REQ_ENABLED:  req_target = ST_ENABLED;
        `BSM_REQ_REMOVAL_REQUEST_ACTIVE:   req_target = ST_REMOVAL_REQUEST_ACTIVE;
        `BSM_REQ_ALLOWED:  req_target = ST_ALLOWED;
        default:           req_target = ST_EMPTY;
      endcase
    end
  endfunction

  function addr_hit;
    input [ADDR_W-1:0] a;
    input [ADDR_W-1:0] off;
    begin
      addr_hit = (a == off);
    end
  endfunction

  // Pin synchronisers
  wire [2:0] pins_s;

  bsm_sync #(
    .WIDTH (3)
  ) u_sync (
    .clk    (CLK_SYS),
    .arst_n (ARST_N),
    .d_in   ({REMOVAL_BUTTON, ISOCHRONOUS_BUS_PRESENCE, SERIAL_BUS_PRESENCE}),
    .d_out  (pins_s)
  );

  wire serial_bus_presence_flag      = pins_s[0];
  wire isochronous_bus_presence_flag = pins_s[1];
  wire button_s                      = pins_s[2];

  reg        status_change_enable_q;
  reg        removal_request_enable_q;
  reg  [2:0] bay_state_request_q;
  reg        status_change_flag_q;
  reg        removal_request_flag_q;
  reg        present_q;
  reg        button_q;
  reg  [2:0] state_q;
  reg  [2:0] state_d;

  wire device_present = serial_bus_presence_flag | isochronous_bus_presence_flag;
  wire arrive         = device_present & ~present_q;
  wire depart         = ~device_present & present_q;
  wire removal_request_active = removal_request_flag_q & removal_request_enable_q;

  wire setup_ok = PSEL & ~PENABLE;
  wire access   = PSEL & PENABLE;
  wire wr_acc   = access & PWRITE & PREADY;
  wire hit_ctrl = addr_hit(PADDR, `BSM_OFF_CTRL);
  wire hit_sts  = addr_hit(PADDR, `BSM_OFF_STATUS);
  wire hit_st   = addr_hit(PADDR, `BSM_OFF_STATE);
  wire mapped   = hit_ctrl | hit_sts | hit_st;

  wire ctrl_wr  = wr_acc & hit_ctrl & PSTRB[0];
  wire sts_wr   = wr_acc & hit_sts & PSTRB[0];
  wire [2:0] wr_req = PWDATA[`BSM_CTRL_REQ_MSB:`BSM_CTRL_REQ_LSB];
  wire [2:0] wr_tgt = req_target(wr_req);
  // The write itself is the trigger; the stored field is readback only
  wire sw_go    = ctrl_wr & device_present & (wr_tgt != ST_EMPTY);

  // Enable rising edge with device already present also counts as arrival
  wire sce_rise = ctrl_wr & PWDATA[`BSM_CTRL_SCE_BIT] & ~status_change_enable_q;

  // Next state: presence loss outranks everything, then software, then button
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_EMPTY: begin
        if (sw_go) begin
          state_d = wr_tgt;
        end else if (device_present && (
                     (arrive && status_change_enable_q) || sce_rise)) begin
          state_d = ST_INSERTED;
        end
      end
      ST_INSERTED: begin
        if (!device_present) begin
          state_d = ST_EMPTY;
        end else if (sw_go) begin
          state_d = wr_tgt;
        end else if (removal_request_active) begin
          state_d = ST_REMOVAL_REQUEST_ACTIVE;
        end
      end
      ST_ENABLED: begin
        if (!device_present) begin
          state_d = ST_EMPTY;
        end else if (sw_go) begin
          state_d = wr_tgt;
        end else if (removal_request_active) begin
          state_d = ST_REMOVAL_REQUEST_ACTIVE;
        end
      end
      ST_REMOVAL_REQUEST_ACTIVE: begin
        if (!device_present) begin
          state_d = ST_EMPTY;
        end else if (sw_go) begin
          state_d = wr_tgt;
        end
      end
      ST_ALLOWED: begin
        if (!device_present) begin
          state_d = ST_EMPTY;
        end else if (sw_go) begin
          state_d = wr_tgt;
        end
      end
      default: state_d = ST_EMPTY;
    endcase
  end
  // Software can never select Empty: wr_tgt is non-empty whenever sw_go is set

  always @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      state_q   <= ST_EMPTY;
      BAY_STATE <= ST_EMPTY;
      present_q <= 1'b0;
      button_q  <= 1'b0;
    end else begin
      state_q   <= state_d;
      BAY_STATE <= state_d;
      present_q <= device_present;
      button_q  <= button_s;
    end
  end

  // Control register and sticky flags; hardware set wins over software clear
  always @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      status_change_enable_q   <= 1'b0;
      removal_request_enable_q <= 1'b0;
      bay_state_request_q      <= 3'h0;
      status_change_flag_q     <= 1'b0;
      removal_request_flag_q   <= 1'b0;
    end else begin
      if (ctrl_wr) begin
        status_change_enable_q   <= PWDATA[`BSM_CTRL_SCE_BIT];
        removal_request_enable_q <= PWDATA[`BSM_CTRL_RRE_BIT];
        bay_state_request_q      <= wr_req;
      end
      if (arrive || depart) begin
        status_change_flag_q <= 1'b1;
      end else if (sts_wr && PWDATA[`BSM_STS_SCF_BIT]) begin
        status_change_flag_q <= 1'b0;
      end
      if (button_s && !button_q) begin
        removal_request_flag_q <= 1'b1;
      end else if ((sts_wr && PWDATA[`BSM_STS_RRF_BIT]) || !device_present) begin
        removal_request_flag_q <= 1'b0;
      end
    end
  end

  // APB answer: no wait state, ready in the first access cycle
  always @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA  <= 32'h00000000;
    end else begin
      PREADY  <= setup_ok;
      PSLVERR <= setup_ok & ~mapped;
      PRDATA  <= 32'h00000000;
      if (setup_ok && !PWRITE) begin
        if (hit_ctrl) begin
          PRDATA <= {25'h0000000, bay_state_request_q, 2'h0,
                     removal_request_enable_q, status_change_enable_q};
        end else if (hit_sts) begin
          PRDATA <= {28'h0000000, status_change_flag_q, removal_request_flag_q,
                     isochronous_bus_presence_flag, serial_bus_presence_flag};
        end else if (hit_st) begin
          PRDATA <= {29'h00000000, state_q};
        end
      end
    end
  end

endmodule // bsm_bay_state_machine

/* dv/bsm_checker_assertions.sv */
module bsm_checker #(
  parameter int ADDR_W = 12
) (
  // Clock and reset
  input wire logic              CLK_SYS,
  input wire logic              ARST_N,
  // APB request
  input wire logic              PSEL,
  input wire logic              PENABLE,
  input wire logic              PWRITE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic [31:0]       PWDATA,
  input wire logic [3:0]        PSTRB,
  input wire logic              PREADY,
  // Pins and state
  input wire logic              SERIAL_BUS_PRESENCE,
  input wire logic              ISOCHRONOUS_BUS_PRESENCE,
  input wire logic              REMOVAL_BUTTON,
  input wire logic [2:0]        BAY_STATE
);
  logic [2:0] pres_q;
  logic       sce_q;
  logic       rre_q;
  wire        pin  = SERIAL_BUS_PRESENCE | ISOCHRONOUS_BUS_PRESENCE;
  // Three samples cover the two-stage pin sync plus the state register
  wire        occ  = &pres_q & pin;
  wire        gone = ~|pres_q & ~pin;
  wire        wr   = PSEL & PENABLE & PREADY & PWRITE & PSTRB[0] & (PADDR == '0);
  wire [2:0]  code = PWDATA[6:4];

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      pres_q <= 3'h0;
      sce_q  <= 1'b0;
      rre_q  <= 1'b0;
    end else begin
      pres_q <= {pres_q[1:0], pin};
      if (wr) begin
        sce_q <= PWDATA[0];
        rre_q <= PWDATA[1];
      end
    end
  end

  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!ARST_N);

  sequence s_req;
    wr && occ;
  endsequence
  sequence s_btn;
    $rose(REMOVAL_BUTTON) && rre_q && BAY_STATE == 3'h2 ##0 (occ && !PSEL) [*6];
  endsequence

  a_wr_valid_code: assert property (s_req ##0 code inside {[3'h1:3'h4]}
    |=> BAY_STATE == $past(code)) else $error("request not taken");
  a_bad_code_hold: assert property (s_req ##0 !(code inside {[3'h1:3'h4]})
    && BAY_STATE != 3'h0 && !rre_q |=> $stable(BAY_STATE)) else $error("bad code moved");
  a_empty_ignore: assert property (wr && gone && BAY_STATE == 3'h0
    |=> BAY_STATE == 3'h0) else $error("request taken while empty");
  a_hold_no_write: assert property (occ && !wr && BAY_STATE >= 3'h3
    |=> $stable(BAY_STATE)) else $error("state moved without write");
  a_loss_to_empty: assert property (!pin [*3] |=> BAY_STATE == 3'h0)
    else $error("loss not seen");
  a_hw_only_empty: assert property ($changed(BAY_STATE) && BAY_STATE == 3'h0
    |-> $past(pres_q[1:0]) != 2'h3) else $error("empty without loss");
  a_arrival_moves: assert property (occ && $past(occ) && sce_q && $past(sce_q, 2)
    |-> BAY_STATE != 3'h0) else $error("arrival ignored");
  a_button_removal_request_active: assert property (s_btn |=> BAY_STATE == 3'h3)
    else $error("button ignored");
endmodule // bsm_checker

bind bsm_bay_state_machine bsm_checker #(.ADDR_W(ADDR_W)) i_chk (.*);

/* dv/bsm_apb_host.sv */
module bsm_apb_host (
  // Clock
  input  wire logic        clk,
  // APB request
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [11:0]      paddr,
  output logic [31:0]      pwdata,
  output logic [3:0]       pstrb,
  // APB answer
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
  // Each call is one deliberate request: a stored code is never rewritten
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
    @(posedge clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    pstrb  <= 4'hF;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule // bsm_apb_host

/* dv/tb_bay_state_machine.sv */
module tb_bay_state_machine;
  timeunit 1ns;
  timeprecision 1ps;
  `define CHK(n, e, a) begin check_count++; if ((a) !== (e)) begin n_errors++; \
    $display("CHECK FAILED %s exp %0h got %0h", n, e, a); end end
  logic        clk = 1'b0, arst_n = 1'b0, sbp = 1'b0, ibp = 1'b0, btn = 1'b0;
  logic        psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb;
  logic [2:0]  st;
  int          n_errors = 0, check_count = 0, cyc = 0;

  bsm_bay_state_machine i_dut (.CLK_SYS(clk), .ARST_N(arst_n), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .SERIAL_BUS_PRESENCE(sbp),
    .ISOCHRONOUS_BUS_PRESENCE(ibp), .REMOVAL_BUTTON(btn), .BAY_STATE(st));
  bsm_apb_host i_host (.clk(clk), .*);

  initial forever #2.5 clk = ~clk;

  task automatic final_report;
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic wr(input logic [2:0] c, input logic [1:0] en, input logic [2:0] e);
    i_host.xfer(1'b1, 12'h000, {25'h0, c, 2'h0, en}, rd, err);
    @(negedge clk);
    `CHK("state after write", e, st)
  endtask

  // Pins are held four edges so the sync stages have settled before the check
  task automatic pres(input logic s, input logic i, input logic [2:0] e);
    @(posedge clk);
    sbp <= s;
    ibp <= i;
    repeat (4) @(posedge clk);
    @(negedge clk);
    `CHK("state after pins", e, st)
  endtask

  // Register read compared against the value the rules predict
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    i_host.xfer(1'b0, a, 32'h0, rd, err);
    `CHK("read data", e, rd)
  endtask

  task automatic t_empty;
    for (int c = 1; c <= 4; c++) wr(c[2:0], 2'h0, 3'h0);
    i_host.xfer(1'b0, 12'hFFC, 32'h0, rd, err);
    `CHK("unmapped error", 1'b1, err)
  endtask

  task automatic t_sw;
    pres(1'b1, 1'b0, 3'h0);
    wr(3'h1, 2'h0, 3'h1);
    wr(3'h0, 2'h0, 3'h1);
    wr(3'h2, 2'h0, 3'h2);
    wr(3'h3, 2'h0, 3'h3);
    wr(3'h2, 2'h0, 3'h2);
    wr(3'h3, 2'h0, 3'h3);
    wr(3'h4, 2'h0, 3'h4);
    wr(3'h7, 2'h0, 3'h4);
    rdc(12'h000, 32'h00000070);
    rdc(12'h008, 32'h00000004);
    pres(1'b1, 1'b0, 3'h4);
    pres(1'b0, 1'b0, 3'h0);
    pres(1'b0, 1'b1, 3'h0);
    wr(3'h2, 2'h0, 3'h2);
    pres(1'b0, 1'b0, 3'h0);
    pres(1'b0, 1'b1, 3'h0);
    wr(3'h1, 2'h0, 3'h1);
    wr(3'h4, 2'h0, 3'h4);
    wr(3'h3, 2'h0, 3'h3);
    pres(1'b0, 1'b0, 3'h0);
  endtask

  task automatic t_hw;
    wr(3'h0, 2'h3, 3'h0);
    pres(1'b1, 1'b1, 3'h1);
    rdc(12'h004, 32'h0000000B);
    wr(3'h2, 2'h3, 3'h2);
    @(posedge clk);
    btn <= 1'b1;
    repeat (8) @(posedge clk);
    @(negedge clk);
    `CHK("button request", 3'h3, st)
    btn <= 1'b0;
    rdc(12'h004, 32'h0000000F);
    pres(1'b0, 1'b0, 3'h0);
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      n_errors++;
      final_report();
    end
  end

  initial begin
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    @(negedge clk);
    `CHK("reset state", 3'h0, st)
    t_empty();
    t_sw();
    t_hw();
    final_report();
  end
endmodule // tb_bay_state_machine
